/* dv/att_host_model.sv */
// Host-side sink that takes every pushed sample and clock mark.
// Assumes one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module att_host_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        sample_valid,
  input  wire logic        sample_clk_out,
  output logic      [15:0] rx_count_reg,
  output logic      [15:0] clk_count_reg
);
  // Takes each sample
  // Never stalls, so any lateness flag is the device's own
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_count_reg <= 16'h0000;
    end else if (sample_valid) begin
      rx_count_reg <= rx_count_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_count_reg <= 16'h0000;
    end else if (sample_clk_out) begin
      clk_count_reg <= clk_count_reg + 16'h0001;
    end
  end
endmodule : att_host_model

/* dv/att_top_monitor.sv */
// Port checker for the acquisition timing block.
// Assumes one clock domain and a master that drops cyc after ack.
`timescale 1ns/1ps
module att_top_monitor #(
  parameter int NBP = 8
) (
  input wire logic           SYS_CLK,
  input wire logic           ARST_N,
  input wire logic           WB_CYC_I,
  input wire logic           WB_STB_I,
  input wire logic           WB_WE_I,
  input wire logic [31:0]    WB_DAT_O,
  input wire logic           WB_ACK_O,
  input wire logic           SAMPLE_CLK_OUT,
  input wire logic           SAMPLE_VALID,
  input wire logic           FRONT_TRIGGER_PIN_OUT,
  input wire logic           FRONT_TRIGGER_PIN_OE,
  input wire logic [NBP-1:0] BP_TRIG_OUT,
  input wire logic [NBP-1:0] BP_TRIG_OE
);
  logic seen_clk_reg;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);
  // Data may only follow a clock mark
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      seen_clk_reg <= 1'b0;
    end else if (SAMPLE_CLK_OUT) begin
      seen_clk_reg <= 1'b1;
    end
  end
  sequence s_taken;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  property p_ack_one;
    s_taken |=> s_ack_pulse;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack not one cycle after request");
  property p_ack_cause;
    WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I && !WB_ACK_O);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_hold;
    $changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I;
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data moved outside a read");
  property p_sclk_pulse;
    SAMPLE_CLK_OUT |=> !SAMPLE_CLK_OUT;
  endproperty
  a_sclk_pulse: assert property (p_sclk_pulse)
    else $error("sample clock mark too long");
  property p_valid_pulse;
    $rose(SAMPLE_VALID) |=> !SAMPLE_VALID;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("sample valid too long");
  property p_valid_after_clk;
    SAMPLE_VALID |-> seen_clk_reg && !SAMPLE_CLK_OUT;
  endproperty
  a_valid_after_clk: assert property (p_valid_after_clk)
    else $error("sample returned before its clock");
  property p_oe_onehot;
    $onehot0(BP_TRIG_OE);
  endproperty
  a_oe_onehot: assert property (p_oe_onehot)
    else $error("more than one backplane line driven");
  property p_front_evt;
    FRONT_TRIGGER_PIN_OUT |-> FRONT_TRIGGER_PIN_OE ##1 !FRONT_TRIGGER_PIN_OUT;
  endproperty
  a_front_evt: assert property (p_front_evt)
    else $error("front event undriven or long");
  property p_bp_evt;
    (|BP_TRIG_OUT) |-> (&BP_TRIG_OUT) ##1 (BP_TRIG_OUT == '0);
  endproperty
  a_bp_evt: assert property (p_bp_evt)
    else $error("backplane event malformed");
endmodule : att_top_monitor
bind att_top att_top_monitor #(.NBP(NBP)) u_mon (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .SAMPLE_CLK_OUT(SAMPLE_CLK_OUT),
  .SAMPLE_VALID(SAMPLE_VALID), .FRONT_TRIGGER_PIN_OUT(FRONT_TRIGGER_PIN_OUT),
  .FRONT_TRIGGER_PIN_OE(FRONT_TRIGGER_PIN_OE), .BP_TRIG_OUT(BP_TRIG_OUT),
  .BP_TRIG_OE(BP_TRIG_OE));

/* dv/tb.sv */
// Self-checking bench for the acquisition timing block.
// Assumes imported sample clock for speed; trigger pins resolved here.
`timescale 1ns/1ps
`include "att_map.svh"
module tb
  import att_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, refok = 1'b1, ext = 1'b0, fdrv = 1'b1;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [7:0]  bdrv = 8'h00;
  logic [95:0] demod = 96'h0, ent, ent_w;
  wire  [31:0] rdat;
  wire  [95:0] sdat;
  wire  [7:0]  bout, boe, bpin;
  wire         ack, fout, foe, fpin, ovs, refsel, sclk, sval;
  wire  [15:0] n_rx, n_clk;
  logic [31:0] rq_e[$], rq_m[$];
  logic [95:0] sq[$];
  int          n_tg = 0;
  logic        pv;
  int          fails = 0, n_tests = 0, fires = 0, bfires = 0, base, f0, b0;
  assign fpin = foe ? fout : fdrv;
  assign bpin = (boe & bout) | (~boe & bdrv);
  always #2.5 clk = ~clk;
  att_top DUT (.SYS_CLK(clk), .ARST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .BP_REF_CLK_SEL_OK(refok), .EXT_SAMPLE_CLK(ext), .BP_TRIG_IN(bpin),
    .FRONT_TRIGGER_PIN_IN(fpin), .DEMOD_DATA(demod),
    .FRONT_TRIGGER_PIN_OUT(fout), .FRONT_TRIGGER_PIN_OE(foe),
    .BP_TRIG_OUT(bout), .BP_TRIG_OE(boe), .OVERSAMPLE_CLK(ovs),
    .REF_SEL_BACKPLANE(refsel), .SAMPLE_CLK_OUT(sclk),
    .SAMPLE_VALID(sval), .SAMPLE_DATA(sdat));
  att_host_model u_host (.clk(clk), .arst_n(rst_n), .sample_valid(sval),
    .sample_clk_out(sclk), .rx_count_reg(n_rx), .clk_count_reg(n_clk));
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp32
  task automatic cmp96(input logic [95:0] g, input logic [95:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp96
  // Classic cycle: hold all until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 40);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (t >= 40) fails++;
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    rq_e.push_back(e);
    rq_m.push_back(m);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : rd
  // Data held well past the synchroniser's latch point
  task automatic tick(input logic [95:0] d, input bit expect_smp);
    @(posedge clk);
    demod <= d;
    ext <= 1'b1;
    if (expect_smp) sq.push_back(d);
    repeat (6) @(posedge clk);
    ext <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : tick
  function automatic logic [95:0] rnd96();
    return {$urandom(), $urandom(), $urandom()};
  endfunction : rnd96
  function automatic logic [95:0] lvl(input logic [23:0] v);
    return {48'h0, v, 24'h0};
  endfunction : lvl
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && rq_e.size() != 0) begin
      cmp32(rdat & rq_m.pop_front(), rq_e.pop_front());
    end
  end
  // Unexpected sample compares against its own inverse
  always @(posedge clk) begin
    if (sval === 1'b1) begin
      ent_w = (sq.size() != 0) ? sq.pop_front() : ~sdat;
      cmp96(sdat, ent_w);
    end
    if (fout === 1'b1 && foe === 1'b1) fires++;
    if ((|(bout & boe)) === 1'b1) bfires++;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hf95a));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ATT_REG_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`ATT_REG_OSDIV, 32'h0000_0001, 32'hFFFF_FFFF);
    rd(`ATT_REG_DELAY, `ATT_DELAY_RST, 32'hFFFF_FFFF);
    rd(`ATT_REG_STATUS, 32'h0000_0000, 32'h0000_003F);
    rd(6'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    wb(1'b1, `ATT_REG_DIV, 32'h0000_2000, 4'h3);
    rd(`ATT_REG_DIV, `ATT_DIV_RST, 32'hFFFF_FFFF);
    wr(`ATT_REG_DIV, 32'hFFFF_FFFF);
    rd(`ATT_REG_DIV, 32'h0BEB_C200, 32'hFFFF_FFFF);
    wr(`ATT_REG_DIV, 32'h0000_0000);
    rd(`ATT_REG_DIV, 32'h0000_1E85, 32'hFFFF_FFFF);
    // Half period is OSDIV plus one system cycles
    wr(`ATT_REG_OSDIV, 32'h0000_0003);
    repeat (4) @(posedge clk);
    pv = ovs;
    repeat (20) begin
      @(posedge clk);
      n_tg += (ovs !== pv);
      pv = ovs;
    end
    cmp32(32'(n_tg), 32'h0000_0005);
    $display("T1 registers done");
    wr(`ATT_REG_DELAY, 32'h0000_0004);
    ent = rnd96();
    demod <= ent;
    sq.push_back(ent);
    sq.push_back(ent);
    wr(`ATT_REG_CTRL, 32'h0000_000B);
    repeat (7900) @(posedge clk);
    cmp32({31'h0, refsel}, 32'h0000_0001);
    refok <= 1'b0;
    repeat (3) @(posedge clk);
    cmp32({31'h0, refsel}, 32'h0000_0000);
    refok <= 1'b1;
    wr(`ATT_REG_CTRL, 32'h0000_0000);
    repeat (20) @(posedge clk);
    sq.delete();
    cmp32(32'(n_rx), 32'h0000_0001);
    cmp32({31'h0, refsel}, 32'h0000_0000);
    base = n_clk;
    f0 = n_rx;
    wr(`ATT_REG_CTRL, 32'h0000_0007);
    repeat (5) tick(rnd96(), 1'b1);
    cmp32(32'(n_rx - f0), 32'h0000_0005);
    cmp32(32'(n_clk - base), 32'h0000_0005);
    rd(`ATT_REG_STATUS, 32'h0000_0000, 32'h0000_0001);
    wr(`ATT_REG_CTRL, 32'h0000_0000);
    $display("T2 sample clocks done");
    for (int i = 0; i < 2; i++) begin
      wr(`ATT_REG_CTRL, i ? 32'h0005_8007 : 32'h0000_8037);
      tick(rnd96(), 1'b0);
      if (i) bdrv[5] <= 1'b1;
      else fdrv <= 1'b0;
      repeat (8) @(posedge clk);
      tick(rnd96(), 1'b1);
      tick(rnd96(), 1'b1);
      wr(`ATT_REG_CTRL, 32'h0000_0000);
      fdrv <= 1'b1;
      bdrv <= 8'h00;
    end
    $display("T3 digital start done");
    wr(`ATT_REG_CTRL, 32'h0000_0005);
    ent = rnd96();
    tick(ent, 1'b0);
    repeat (16) tick(rnd96(), 1'b0);
    rd(`ATT_REG_COUNT, 32'h0000_0010, 32'h0000_FFFF);
    rd(`ATT_REG_STATUS, 32'h0000_0003, 32'h0000_0003);
    for (int k = 0; k < 4; k++) begin
      rd(`ATT_REG_DATA, {8'h00, ent[k*24 +: 24]}, 32'h00FF_FFFF);
    end
    wr(`ATT_REG_STATUS, 32'h0000_0001);
    rd(`ATT_REG_STATUS, 32'h0000_0000, 32'h0000_0001);
    wr(`ATT_REG_CTRL, 32'h0000_0000);
    rd(`ATT_REG_COUNT, 32'h0000_0000, 32'h0000_FFFF);
    $display("T4 buffered done");
    wr(`ATT_REG_PRE, 32'h0000_0002);
    wr(`ATT_REG_POST, 32'h0000_0002);
    wr(`ATT_REG_LVL_HI, 32'h0000_1000);
    wr(`ATT_REG_LVL_LO, 32'h0000_0800);
    for (int m = 0; m < 3; m++) begin
      f0 = fires;
      b0 = bfires;
      wr(`ATT_REG_CTRL, 32'h0000_3145 | (m << 10) | ((m + 1) << 20));
      tick(lvl(m == 2 ? 24'h00_0C00 : 24'h00_2000), 1'b0);
      tick(lvl(24'h00_0100), 1'b0);
      tick(lvl(24'h00_0100), 1'b0);
      cmp32(32'(fires - f0), 32'h0000_0000);
      rd(`ATT_REG_STATUS, 32'h0000_0004, 32'h0000_0004);
      tick(lvl(m == 2 ? 24'h00_0C00 : 24'h00_2000), 1'b0);
      cmp32(32'(fires - f0), 32'h0000_0001);
      cmp32(32'(bfires - b0), 32'h0000_0001);
      tick(lvl(24'h00_0100), 1'b0);
      tick(lvl(24'h00_0100), 1'b0);
      rd(`ATT_REG_STATUS, 32'h0000_0028, 32'h0000_0028);
      wr(`ATT_REG_CTRL, 32'h0000_0000);
    end
    $display("T5 reference trigger done");
    tally_and_finish();
  end
endmodule : tb

/* src/att_map.svh */
// Constants for the acquisition timing and trigger block.
// Assumes a 200 MHz system clock and a classic Wishbone slave.
`ifndef ATT_MAP_SVH
`define ATT_MAP_SVH
`define ATT_CLK_HZ        200_000_000
`define ATT_REF_HZ        100_000_000
`define ATT_RATE_MAX_SPS  25_600
`define ATT_RATE_MIN_SPS  1
`define ATT_REG_CTRL      6'h00
`define ATT_REG_STATUS    6'h04
`define ATT_REG_DIV       6'h08
`define ATT_REG_OSDIV     6'h0C
`define ATT_REG_PRE       6'h10
`define ATT_REG_POST      6'h14
`define ATT_REG_LVL_HI    6'h18
`define ATT_REG_LVL_LO    6'h1C
`define ATT_REG_DATA      6'h20
`define ATT_REG_DELAY     6'h24
`define ATT_REG_COUNT     6'h28
`define ATT_CTRL_RUN      0
`define ATT_CTRL_SPT      1
`define ATT_CTRL_EXTCLK   2
`define ATT_CTRL_BPREF    3
`define ATT_CTRL_SRC      4
`define ATT_CTRL_FALL     5
`define ATT_CTRL_REFEN    6
`define ATT_CTRL_CH_LO    8
`define ATT_CTRL_TMODE_LO 10
`define ATT_CTRL_ROUTE_LO 12
`define ATT_CTRL_START_REQ 15
`define ATT_CTRL_DTRIG    16
`define ATT_ST_OVR        0
`define ATT_ST_FULL       1
`define ATT_ST_ARMED      2
`define ATT_ST_DONE       3
`define ATT_ST_RUN        4
`define ATT_ST_FIRED      5
`define ATT_DIV_RST       32'h0000_1E85
`define ATT_OSDIV_RST     16'h0001
`define ATT_DELAY_RST     32'h0000_0010
`endif

/* src/att_pkg.sv */
// Types for the acquisition timing and trigger block.
// Assumes att_map.svh is on the include path.
package att_pkg;
  typedef enum logic [1:0] {
    ATT_TRIG_LEVEL,
    ATT_TRIG_HYST,
    ATT_TRIG_WINDOW,
    ATT_TRIG_RSVD
  } att_trig_e;
  typedef enum {
    ATT_IDLE,
    ATT_WAIT_START,
    ATT_PRE,
    ATT_ARMED,
    ATT_POST,
    ATT_DONE
  } att_state_e;
endpackage : att_pkg

/* src/att_top.sv */
// Acquisition timing and trigger controller with Wishbone registers.
// Assumes demodulated words arrive synchronous to SYS_CLK, one per
// channel, and that the host pops data through the data register.
`timescale 1ns/1ps
`include "att_map.svh"
module att_top
  import att_pkg::*;
#(
  parameter int NCH   = 4,
  parameter int DW    = 24,
  parameter int DEPTH = 16,
  parameter int NBP   = 8
) (
  input  wire logic              SYS_CLK,
  input  wire logic              ARST_N,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [5:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire logic              BP_REF_CLK_SEL_OK,
  input  wire logic              EXT_SAMPLE_CLK,
  input  wire logic [NBP-1:0]    BP_TRIG_IN,
  input  wire logic              FRONT_TRIGGER_PIN_IN,
  input  wire logic [NCH*DW-1:0] DEMOD_DATA,
  output logic                   FRONT_TRIGGER_PIN_OUT,
  output logic                   FRONT_TRIGGER_PIN_OE,
  output logic [NBP-1:0]         BP_TRIG_OUT,
  output logic [NBP-1:0]         BP_TRIG_OE,
  output logic                   OVERSAMPLE_CLK,
  output logic                   REF_SEL_BACKPLANE,
  output logic                   SAMPLE_CLK_OUT,
  output logic                   SAMPLE_VALID,
  output logic [NCH*DW-1:0]      SAMPLE_DATA
);
  localparam int AW = $clog2(DEPTH);
  // Round up so the clamped rate never exceeds the top rate
  localparam logic [31:0] DIV_MIN =
    32'((`ATT_CLK_HZ + `ATT_RATE_MAX_SPS - 1) / `ATT_RATE_MAX_SPS);
  localparam logic [31:0] DIV_MAX =
    32'(`ATT_CLK_HZ / `ATT_RATE_MIN_SPS);

  function automatic logic [DW-1:0] chan(input logic [NCH*DW-1:0] v,
                                         input logic [1:0] i);
    chan = v[i*DW +: DW];
  endfunction : chan

  logic [31:0]      ctrl_reg, div_reg, pre_reg, post_reg, delay_reg;
  logic [15:0]      osdiv_reg;
  logic [DW-1:0]    lvl_hi_reg, lvl_lo_reg;
  logic             ovr_reg, fired_reg, ack_reg;
  logic [31:0]      dat_reg;
  att_state_e       state_reg;
  logic [31:0]      tick_cnt_reg, pre_cnt_reg, post_cnt_reg;
  logic [31:0]      dly_cnt_reg;
  logic             int_tick_reg;
  logic [15:0]      os_cnt_reg;
  logic             os_clk_reg;
  logic [2:0]       ext_sync_reg;
  logic [2:0]       trig_sync_reg;
  logic             above_reg, hyst_reg;
  logic             pending_reg;
  logic [NCH*DW-1:0] hold_reg;
  logic [NCH*DW-1:0] mem [DEPTH];
  logic [AW:0]      wp_reg, rp_reg;
  logic [1:0]       lane_reg;
  logic             sclk_out_reg, valid_reg, ftp_reg, ref_evt_reg;
  logic [NCH*DW-1:0] sdata_reg;

  wire run     = ctrl_reg[`ATT_CTRL_RUN];
  wire spt     = ctrl_reg[`ATT_CTRL_SPT];
  wire refen   = ctrl_reg[`ATT_CTRL_REFEN];
  wire [1:0] ch_sel = ctrl_reg[`ATT_CTRL_CH_LO +: 2];
  att_trig_e tmode;
  assign tmode = att_trig_e'(ctrl_reg[`ATT_CTRL_TMODE_LO +: 2]);
  wire wb_req  = WB_CYC_I && WB_STB_I && !ack_reg;
  wire wb_wr   = wb_req && WB_WE_I;
  wire data_rd = wb_req && !WB_WE_I && WB_ADR_I == `ATT_REG_DATA;
  wire [AW:0] fill = wp_reg - rp_reg;
  wire empty = fill == '0;
  wire full  = fill == (AW+1)'(DEPTH);

  // Bus slave: one wait state, ack drops after one cycle
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  // clamp pacing divider to rate limits
  // any divider down to 1 S/s allowed
  function automatic logic [31:0] clamp_div(input logic [31:0] d);
    if (d < DIV_MIN) clamp_div = DIV_MIN;
    else if (d > DIV_MAX) clamp_div = DIV_MAX;
    else clamp_div = d;
  endfunction : clamp_div

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg   <= '0;
      div_reg    <= `ATT_DIV_RST;
      osdiv_reg  <= `ATT_OSDIV_RST;
      pre_reg    <= '0;
      post_reg   <= '0;
      lvl_hi_reg <= '0;
      lvl_lo_reg <= '0;
      delay_reg  <= `ATT_DELAY_RST;
    end else if (wb_wr && WB_SEL_I == 4'hF) begin
      unique case (WB_ADR_I)
        `ATT_REG_CTRL:   ctrl_reg   <= WB_DAT_I;
        `ATT_REG_DIV:    div_reg    <= clamp_div(WB_DAT_I);
        `ATT_REG_OSDIV:  osdiv_reg  <= (WB_DAT_I[15:0] == '0) ?
                                       16'h0001 : WB_DAT_I[15:0];
        `ATT_REG_PRE:    pre_reg    <= WB_DAT_I;
        `ATT_REG_POST:   post_reg   <= WB_DAT_I;
        `ATT_REG_LVL_HI: lvl_hi_reg <= WB_DAT_I[DW-1:0];
        `ATT_REG_LVL_LO: lvl_lo_reg <= WB_DAT_I[DW-1:0];
        `ATT_REG_DELAY:  delay_reg  <= WB_DAT_I;
        default: ;
      endcase
    end
  end

  // Read mux; data register pops one channel word per read
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dat_reg <= '0;
    end else if (wb_req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        `ATT_REG_CTRL:   dat_reg <= ctrl_reg;
        `ATT_REG_STATUS: dat_reg <= {26'h0, fired_reg, state_reg != ATT_IDLE,
                                     state_reg == ATT_DONE,
                                     state_reg == ATT_ARMED, full, ovr_reg};
        `ATT_REG_DIV:    dat_reg <= div_reg;
        `ATT_REG_OSDIV:  dat_reg <= {16'h0, osdiv_reg};
        `ATT_REG_PRE:    dat_reg <= pre_reg;
        `ATT_REG_POST:   dat_reg <= post_reg;
        `ATT_REG_LVL_HI: dat_reg <= 32'(lvl_hi_reg);
        `ATT_REG_LVL_LO: dat_reg <= 32'(lvl_lo_reg);
        `ATT_REG_DATA:   dat_reg <= empty ? 32'h0 :
          32'(chan(mem[rp_reg[AW-1:0]], lane_reg));
        `ATT_REG_DELAY:  dat_reg <= delay_reg;
        `ATT_REG_COUNT:  dat_reg <= 32'(fill);
        default:         dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // oversample clock divided from 200 MHz SYS_CLK
  // converters run only from this internal divider
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      os_cnt_reg <= '0;
      os_clk_reg <= 1'b0;
    end else if (os_cnt_reg >= osdiv_reg) begin
      os_cnt_reg <= '0;
      os_clk_reg <= !os_clk_reg;
    end else begin
      os_cnt_reg <= os_cnt_reg + 16'h0001;
    end
  end

  // reference source select, backplane needs lock
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REF_SEL_BACKPLANE <= 1'b0;
      OVERSAMPLE_CLK    <= 1'b0;
    end else begin
      REF_SEL_BACKPLANE <= ctrl_reg[`ATT_CTRL_BPREF] && BP_REF_CLK_SEL_OK;
      OVERSAMPLE_CLK    <= os_clk_reg;
    end
  end

  // two-stage synchronisers, third flop for edges
  wire trig_raw = ctrl_reg[`ATT_CTRL_SRC] ? FRONT_TRIGGER_PIN_IN :
                  BP_TRIG_IN[ctrl_reg[`ATT_CTRL_DTRIG +: 3]];
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_sync_reg  <= '0;
      trig_sync_reg <= '0;
    end else begin
      ext_sync_reg  <= {ext_sync_reg[1:0], EXT_SAMPLE_CLK};
      trig_sync_reg <= {trig_sync_reg[1:0], trig_raw};
    end
  end
  // polarity selects rising or falling edge
  wire dtrig = ctrl_reg[`ATT_CTRL_FALL] ?
               (trig_sync_reg[2] && !trig_sync_reg[1]) :
               (!trig_sync_reg[2] && trig_sync_reg[1]);
  wire ext_tick = !ext_sync_reg[2] && ext_sync_reg[1];

  // internal pacing counter or imported clock
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_reg <= '0;
      int_tick_reg <= 1'b0;
    end else if (!run || tick_cnt_reg >= div_reg - 32'h1) begin
      tick_cnt_reg <= '0;
      int_tick_reg <= run;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      int_tick_reg <= 1'b0;
    end
  end
  // one tick strobes all channels together
  wire tick = ctrl_reg[`ATT_CTRL_EXTCLK] ? (ext_tick && run) : int_tick_reg;

  wire [DW-1:0] mon = chan(DEMOD_DATA, ch_sel);
  wire gt_hi = $signed(mon) > $signed(lvl_hi_reg);
  wire lt_lo = $signed(mon) < $signed(lvl_lo_reg);
  wire in_win = !gt_hi && !lt_lo;
  logic cond;
  // level edge, hysteresis edge, window entry
  always_comb begin
    cond = 1'b0;
    unique case (tmode)
      ATT_TRIG_LEVEL:  cond = gt_hi && !above_reg;
      ATT_TRIG_HYST:   cond = gt_hi && hyst_reg;
      ATT_TRIG_WINDOW: cond = in_win && !above_reg;
      ATT_TRIG_RSVD:   cond = 1'b0;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      above_reg <= 1'b0;
      hyst_reg  <= 1'b0;
    end else if (tick) begin
      above_reg <= (tmode == ATT_TRIG_WINDOW) ? in_win : gt_hi;
      if (lt_lo) hyst_reg <= 1'b1;
      else if (gt_hi) hyst_reg <= 1'b0;
    end
  end

  // Sequencer: start, pre-count, armed, post-count
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg    <= ATT_IDLE;
      pre_cnt_reg  <= '0;
      post_cnt_reg <= '0;
      fired_reg    <= 1'b0;
      ref_evt_reg  <= 1'b0;
    end else begin
      ref_evt_reg <= 1'b0;
      if (!run) begin
        state_reg <= ATT_IDLE;
      end else begin
        unique case (state_reg)
          ATT_IDLE: begin
            fired_reg   <= 1'b0;
            pre_cnt_reg <= '0;
            // start waits for digital trigger only if start request bit set
            state_reg <= ATT_WAIT_START;
          end
          ATT_WAIT_START: begin
            // Own bit, so every backplane line can start a run
            if (dtrig || !ctrl_reg[`ATT_CTRL_START_REQ]) begin
              state_reg <= refen ? ATT_PRE : ATT_POST;
            end
          end
          ATT_PRE: begin
            if (tick) pre_cnt_reg <= pre_cnt_reg + 32'h1;
            if (pre_cnt_reg >= pre_reg) state_reg <= ATT_ARMED;
          end
          ATT_ARMED: begin
            // fire on next condition once armed
            if (tick && cond) begin
              fired_reg    <= 1'b1;
              ref_evt_reg  <= 1'b1;
              post_cnt_reg <= '0;
              state_reg    <= ATT_POST;
            end
          end
          ATT_POST: begin
            // finite post count when reference used
            if (tick && refen) begin
              post_cnt_reg <= post_cnt_reg + 32'h1;
              if (post_cnt_reg + 32'h1 >= post_reg) state_reg <= ATT_DONE;
            end
          end
          ATT_DONE: ;
        endcase
      end
    end
  end
  // samples counted only after start taken
  wire acq_tick = tick && (state_reg == ATT_PRE ||
                           state_reg == ATT_ARMED ||
                           state_reg == ATT_POST);

  // latch at tick, release after filter delay
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dly_cnt_reg <= '0;
      pending_reg <= 1'b0;
      hold_reg    <= '0;
    end else if (acq_tick) begin
      hold_reg    <= DEMOD_DATA;
      pending_reg <= 1'b1;
      dly_cnt_reg <= delay_reg;
    end else if (pending_reg && dly_cnt_reg != '0) begin
      dly_cnt_reg <= dly_cnt_reg - 32'h1;
    end else begin
      pending_reg <= 1'b0;
    end
  end
  wire release_s = pending_reg && dly_cnt_reg == '0 && !acq_tick;

  // buffered mode queues samples for burst reads
  wire push = release_s && !spt && !full;
  wire pop  = data_rd && !empty && lane_reg == 2'(NCH-1);
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wp_reg   <= '0;
      rp_reg   <= '0;
      lane_reg <= '0;
    end else begin
      if (!run) begin
        wp_reg <= '0;
        rp_reg <= '0;
      end else begin
        if (push) wp_reg <= wp_reg + (AW+1)'(1);
        if (pop)  rp_reg <= rp_reg + (AW+1)'(1);
      end
      if (data_rd && !empty) lane_reg <= pop ? 2'd0 : lane_reg + 2'd1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (push) mem[wp_reg[AW-1:0]] <= hold_reg;
  end

  // host late if valid still unread at release
  // sticky until host writes one to clear
  wire late = release_s && ((spt && valid_reg) || (!spt && full));
  wire ovr_clr = wb_wr && WB_ADR_I == `ATT_REG_STATUS &&
                 WB_SEL_I[0] && WB_DAT_I[`ATT_ST_OVR];
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ovr_reg <= 1'b0;
    end else if (late) begin
      ovr_reg <= 1'b1;
    end else if (ovr_clr) begin
      ovr_reg <= 1'b0;
    end
  end

  // single-point pushes each sample at once
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      valid_reg <= 1'b0;
      sdata_reg <= '0;
    end else if (release_s && spt) begin
      valid_reg <= 1'b1;
      sdata_reg <= hold_reg;
    end else begin
      valid_reg <= 1'b0;
    end
  end
  assign SAMPLE_VALID = valid_reg;
  assign SAMPLE_DATA  = sdata_reg;

  // reference event routed to trigger outputs
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_out_reg <= 1'b0;
      ftp_reg      <= 1'b0;
      BP_TRIG_OUT  <= '0;
      BP_TRIG_OE   <= '0;
      FRONT_TRIGGER_PIN_OE <= 1'b0;
    end else begin
      sclk_out_reg <= tick;
      ftp_reg      <= ref_evt_reg && ctrl_reg[`ATT_CTRL_ROUTE_LO];
      FRONT_TRIGGER_PIN_OE <= ctrl_reg[`ATT_CTRL_ROUTE_LO];
      BP_TRIG_OE   <= ctrl_reg[`ATT_CTRL_ROUTE_LO + 1] ?
                      NBP'(1) << ctrl_reg[`ATT_CTRL_DTRIG + 4 +: 3] : '0;
      BP_TRIG_OUT  <= ref_evt_reg ? '1 : '0;
    end
  end
  assign SAMPLE_CLK_OUT        = sclk_out_reg;
  assign FRONT_TRIGGER_PIN_OUT = ftp_reg;
endmodule : att_top
